// ### src/pdm_dec_top.sv
// Function
// - Decimate each PDM channel by a fixed 64, no other ratio.
// - Passband flat within -0.1/+0.01 dB up to 0.45 fs.
// - Valid PCM appears within 63 to 64 frames after clocks start.
// - Work for bit clocks to 24.576 MHz and frame rates 4 to 96 kHz.
// - Frame sync sampled on bit clock rising edge.
// - Serial data changes only after bit clock falling edges, or clears to 0 on entering shutdown.
// - Mic data captured on both edges of generated mic clock.
// - Serial port is slave only; bit clock and frame sync are inputs.
// - Loss of bit clock and frame sync drops into low-power shutdown.
// - Detect bits per frame; mic clock runs at 64 times frame rate when bits per frame is a multiple of 64.
// - Falling-edge data feeds channel 0, rising-edge data channel 1.
// - Each channel is held in 26-bit accumulators internally and output as a 24-bit PCM word.
// - Wait for the 16th frame sync (15 whole frames) after clocks arrive before driving mic clock.
`timescale 1ns/1ps
`include "pdm_defines.svh"
module pdm_dec_top
  import pdm_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic SYS_RST,
  input  wire logic CE,
  input  wire logic BCLK_IN,
  input  wire logic FRAME_SYNC_IN,
  input  wire logic MIC_BITSTREAM_IN,
  output logic      MIC_CLOCK_OUT,
  output logic      SERIAL_AUDIO_OUT,
  output logic      LOW_POWER_OUT
);
  localparam int AW = `PDM_ACC_W;
  localparam int PW = `PDM_PCM_W;
  localparam int NS = `PDM_CIC_N;

  function automatic logic signed [PW-1:0] comp_sat(input logic signed [AW-1:0] a,
                                                    input logic signed [AW-1:0] b,
                                                    input logic signed [AW-1:0] c);
    logic signed [AW+3:0] s;
    s = (AW+4)'(b) * 10 - (AW+4)'(a) - (AW+4)'(c);
    s = s >>> 4;
    if (s > (AW+4)'(8388607)) return 24'h7F_FFFF;
    if (s < -(AW+4)'(8388608)) return 24'h80_0000;
    return s[PW-1:0];
  endfunction

  // Pin synchronisers, stage 1 read only by stage 2
  logic [2:0] bclk_sq_q, bclk_sq_d;
  logic [1:0] fs_sq_q, fs_sq_d;
  logic [1:0] dat_sq_q, dat_sq_d;
  logic       b_rise, b_fall, frame_start;

  pdm_state_t st_q, st_d;
  logic [9:0] bcnt_q, bcnt_d, bits_q, bits_d;
  logic [3:0] ecnt_q, ecnt_d, k;
  logic [7:0] idle_q, idle_d;
  logic [4:0] wcnt_q, wcnt_d, wtgt_q, wtgt_d;
  logic [6:0] fcnt_q, fcnt_d;
  logic [`PDM_SLOT_W-1:0] sh_q, sh_d;
  logic       fs_last_q, fs_last_d, pdm_q, pdm_d, sd_q, sd_d, tog;

  logic signed [AW-1:0] integ_q [2][NS];
  logic signed [AW-1:0] integ_d [2][NS];
  logic signed [AW-1:0] dly_q [2][NS];
  logic signed [AW-1:0] dly_d [2][NS];
  logic signed [AW-1:0] h1_q [2];
  logic signed [AW-1:0] h1_d [2];
  logic signed [AW-1:0] h2_q [2];
  logic signed [AW-1:0] h2_d [2];
  logic signed [AW-1:0] cv [2];
  logic signed [AW-1:0] x;
  logic [PW-1:0] pcm [2];
  logic [5:0]  dcnt_q, dcnt_d;
  logic        cap_ch1, dec_evt;
  logic        f_in_rdy, f_out_vld, f_pop;
  logic [2*PW-1:0] f_out_data;

  assign b_rise      = bclk_sq_q[1] & ~bclk_sq_q[2];
  assign b_fall      = ~bclk_sq_q[1] & bclk_sq_q[2];
  assign frame_start = b_rise & fs_sq_q[1] & ~fs_last_q;
  assign k           = bits_q[9:6];
  assign f_pop       = frame_start & f_out_vld;

  assign MIC_CLOCK_OUT    = pdm_q;
  assign SERIAL_AUDIO_OUT = sd_q;
  assign LOW_POWER_OUT    = st_q[0];

  // Link sampling, frame tracking, mic clock and serial output
  always_comb begin
    bclk_sq_d = {bclk_sq_q[1:0], BCLK_IN};
    fs_sq_d   = {fs_sq_q[0], FRAME_SYNC_IN};
    dat_sq_d  = {dat_sq_q[0], MIC_BITSTREAM_IN};
    st_d      = st_q;
    bcnt_d    = bcnt_q;
    bits_d    = bits_q;
    ecnt_d    = ecnt_q;
    wcnt_d    = wcnt_q;
    wtgt_d    = wtgt_q;
    fcnt_d    = fcnt_q;
    sh_d      = sh_q;
    fs_last_d = fs_last_q;
    pdm_d     = pdm_q;
    sd_d      = sd_q;
    tog       = 1'b0;
    idle_d    = (b_rise | b_fall) ? '0 :
                (idle_q == 8'(`PDM_STOP_CYC)) ? idle_q : idle_q + 1'b1;
    if (b_rise) begin
      fs_last_d = fs_sq_q[1];
      bcnt_d    = frame_start ? '0 : bcnt_q + 1'b1;
    end
    if (frame_start) begin
      bits_d = bcnt_q + 1'b1;
      if (fcnt_q != 7'h7F) fcnt_d = fcnt_q + 1'b1;
      sh_d = (f_out_vld && fcnt_q >= `PDM_VALID_FRAMES) ?
             {f_out_data[2*PW-1:PW], 8'h00, f_out_data[PW-1:0], 8'h00} : '0;
    end else if (b_fall) begin
      sd_d = sh_q[`PDM_SLOT_W-1];
      sh_d = {sh_q[`PDM_SLOT_W-2:0], 1'b0};
    end
    case (st_q)
      ST_OFF: begin
        if (b_rise | b_fall) begin
          st_d   = ST_WAIT;
          wcnt_d = '0;
          wtgt_d = `PDM_START_FRAMES;
        end
      end
      ST_WAIT: begin
        if (frame_start) begin
          wcnt_d = wcnt_q + 1'b1;
          if (wcnt_d >= wtgt_q && bits_d >= `PDM_MIN_BITS) begin
            st_d   = ST_RUN;
            ecnt_d = '0;
          end
        end
      end
      ST_RUN: begin
        if (b_rise | b_fall) begin
          if (ecnt_q + 1'b1 >= k) begin
            ecnt_d = '0;
            pdm_d  = ~pdm_q;
            tog    = 1'b1;
          end else begin
            ecnt_d = ecnt_q + 1'b1;
          end
        end
        if (frame_start && bits_d != bits_q) begin
          st_d   = ST_WAIT;
          pdm_d  = 1'b0;
          tog    = 1'b0;
          wcnt_d = '0;
          wtgt_d = `PDM_RELOCK_FRAMES;
        end
      end
      default: st_d = ST_OFF;
    endcase
    // A fresh edge in shutdown must win, or the first edge is lost
    if (idle_q == 8'(`PDM_STOP_CYC) && !(b_rise | b_fall)) begin
      st_d   = ST_OFF;
      pdm_d  = 1'b0;
      sd_d   = 1'b0;
      sh_d   = '0;
      fcnt_d = '0;
      tog    = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      bclk_sq_q <= '0;
      fs_sq_q   <= '0;
      dat_sq_q  <= '0;
      st_q      <= ST_OFF;
      bcnt_q    <= '0;
      bits_q    <= '0;
      ecnt_q    <= '0;
      idle_q    <= '0;
      wcnt_q    <= '0;
      wtgt_q    <= `PDM_START_FRAMES;
      fcnt_q    <= '0;
      sh_q      <= '0;
      fs_last_q <= 1'b0;
      pdm_q     <= 1'b0;
      sd_q      <= 1'b0;
    end else if (CE) begin
      bclk_sq_q <= bclk_sq_d;
      fs_sq_q   <= fs_sq_d;
      dat_sq_q  <= dat_sq_d;
      st_q      <= st_d;
      bcnt_q    <= bcnt_d;
      bits_q    <= bits_d;
      ecnt_q    <= ecnt_d;
      idle_q    <= idle_d;
      wcnt_q    <= wcnt_d;
      wtgt_q    <= wtgt_d;
      fcnt_q    <= fcnt_d;
      sh_q      <= sh_d;
      fs_last_q <= fs_last_d;
      pdm_q     <= pdm_d;
      sd_q      <= sd_d;
    end
  end

  // Fourth-order CIC by 64 plus droop compensator, both channels
  always_comb begin
    integ_d = integ_q;
    dly_d   = dly_q;
    h1_d    = h1_q;
    h2_d    = h2_q;
    dcnt_d  = dcnt_q;
    cap_ch1 = ~pdm_q;
    x       = dat_sq_q[1] ? AW'(1) : -AW'(1);
    dec_evt = tog & cap_ch1 & (dcnt_q == 6'h3F);
    for (int c = 0; c < 2; c++) begin
      cv[c] = integ_q[c][NS-1];
      for (int s = 0; s < NS; s++) begin
        if (dec_evt && f_in_rdy) dly_d[c][s] = cv[c];
        cv[c] = cv[c] - dly_q[c][s];
      end
      pcm[c] = comp_sat(cv[c], h1_q[c], h2_q[c]);
      if (dec_evt && f_in_rdy) begin
        h1_d[c] = cv[c];
        h2_d[c] = h1_q[c];
      end
    end
    if (tog) begin
      for (int c = 0; c < 2; c++) begin
        if ((c == 1) == cap_ch1) begin
          integ_d[c][0] = integ_q[c][0] + x;
          for (int s = 1; s < NS; s++) integ_d[c][s] = integ_q[c][s] + integ_q[c][s-1];
        end
      end
      if (cap_ch1) dcnt_d = dcnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      integ_q <= '{default: '0};
      dly_q   <= '{default: '0};
      h1_q    <= '{default: '0};
      h2_q    <= '{default: '0};
      dcnt_q  <= '0;
    end else if (CE) begin
      integ_q <= integ_d;
      dly_q   <= dly_d;
      h1_q    <= h1_d;
      h2_q    <= h2_d;
      dcnt_q  <= dcnt_d;
    end
  end

  pdm_fifo #(
    .W (2*PW),
    .D (`PDM_FIFO_DEPTH)
  ) u_fifo (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .ce       (CE),
    .clr      (st_q == ST_OFF),
    .in_vld   (dec_evt),
    .in_rdy   (f_in_rdy),
    .in_data  ({pcm[0], pcm[1]}),
    .out_vld  (f_out_vld),
    .out_rdy  (f_pop),
    .out_data (f_out_data)
  );

  // Helper: mic clock rises between two decimated outputs
  logic [7:0] rcnt_q;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) rcnt_q <= '0;
    else if (CE && dec_evt) rcnt_q <= '0;
    else if (CE && tog && cap_ch1) rcnt_q <= rcnt_q + 1'b1;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_off_quiet:   assert property (st_q == ST_OFF |-> !pdm_q && !sd_q) else $error("activity in shutdown");
  a_wait_quiet:  assert property (st_q == ST_WAIT |-> !pdm_q) else $error("mic clock during wait");
  a_run_late:    assert property ($rose(st_q == ST_RUN) |-> fcnt_q >= 7'h10) else $error("mic clock too early");
  a_pdm_edge:    assert property ($changed(pdm_q) && st_q == ST_RUN && $past(st_q) == ST_RUN
                                  |-> $past(b_rise || b_fall)) else $error("mic clock off edge");
  a_sd_fall:     assert property ($changed(sd_q) |-> $past(b_fall) || st_q == ST_OFF)
                   else $error("data changed off falling edge");
  a_zero_early:  assert property (fcnt_q < 7'h40 |-> !sd_q) else $error("data before valid");
  a_ch1_rise:    assert property ($changed(dcnt_q) |-> $rose(pdm_q)) else $error("channel map wrong");
  a_osr_count:   assert property (dec_evt |-> rcnt_q == 8'h3F) else $error("ratio not 64");
  a_ratio_range: assert property (st_q == ST_RUN |-> bits_q >= `PDM_MIN_BITS && k != 0)
                   else $error("bad frame ratio");
  a_fs_rise:     assert property ($changed(fs_last_q) |-> $past(b_rise)) else $error("sync off rising edge");

  c_run:      cover property ($rose(st_q == ST_RUN));
  c_data_out: cover property (f_pop && fcnt_q >= `PDM_VALID_FRAMES);
  c_shutdown: cover property ($rose(st_q == ST_OFF));
  c_stall:    cover property (dec_evt && !f_in_rdy);

endmodule

// ### src/pdm_defines.svh
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

// Decimation and sample format
`define PDM_OSR           64
`define PDM_CIC_N         4
`define PDM_ACC_W         26
`define PDM_PCM_W         24
`define PDM_SLOT_W        64

// Frame counts for start-up and relock, minimum bits per frame
`define PDM_START_FRAMES  5'h10
`define PDM_RELOCK_FRAMES 5'h04
`define PDM_VALID_FRAMES  7'h3F
`define PDM_MIN_BITS      10'h040

// Clock-loss watchdog
`define MIC_CLOCK_OUT_NS        40
`define PDM_STOP_NS       4000
`define PDM_STOP_CYC      (`PDM_STOP_NS / `MIC_CLOCK_OUT_NS)

`define PDM_FIFO_DEPTH    8

`endif

// ### src/pdm_pkg.sv
package pdm_pkg;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN  = 3'h4
  } pdm_state_t;

endpackage

// ### src/pdm_fifo.sv
`timescale 1ns/1ps
module pdm_fifo #(
  parameter int W = 48,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         in_vld,
  output logic              in_rdy,
  input  wire logic [W-1:0] in_data,
  output logic              out_vld,
  input  wire logic         out_rdy,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_rdy   = (cnt_q != D[AW:0]);
  assign out_vld  = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push     = in_vld & in_rdy;
  assign pop      = out_vld & out_rdy;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (clr) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_d = cnt_q + 1'b1;
      else if (pop && !push) cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push && !clr) mem[wr_q] <= in_data;
  end

endmodule

// ### test/pdm_host_model.sv
`timescale 1ns/1ps
module pdm_host_model (
  input  wire logic   run,
  input  wire logic   sd,
  input  wire logic   mclk,
  input  int          bpf,
  output logic        bclk,
  output logic        fs,
  output logic        mdat,
  output logic [63:0] word,
  output int          frames,
  output int          mrises
);
  int          nxt;
  int          mcnt;
  int          pidx;
  logic [63:0] sh;

  // Bit clock of 320 ns, edges fixed at 13 ns after a system clock falling edge
  initial begin
    bclk = 0;
    fs = 0;
    word = '0;
    frames = 0;
    mrises = 0;
    nxt = 63;
    mcnt = 0;
    pidx = 0;
    sh = '0;
    #13;
    forever begin
      #160;
      if (run || bclk) begin
        bclk = ~bclk;
        if (!bclk) begin
          nxt = (nxt + 1) % bpf;
          fs = (nxt == 0);
        end else begin
          sh = {sh[62:0], sd};
          if (nxt == 0) begin
            word = sh;
            frames++;
            mrises = mcnt;
            mcnt = 0;
          end
        end
      end else begin
        fs = 0;
      end
    end
  end

  // Next bit for the other channel after each edge
  always @(mclk) begin
    #5;
    if (mclk) begin
      mcnt++;
      mdat = (pidx % 4 != 3);
    end else begin
      mdat = (pidx % 4 == 3);
      pidx++;
    end
  end
endmodule

// ### test/tb_pdm_dec_top.sv
`timescale 1ns/1ps
module tb_pdm_dec_top;
  logic        clk_sys;
  logic        sys_rst;
  logic        ce;
  logic        run;
  int          bpf;
  logic        bclk;
  logic        frame_sync_in;
  logic        mdat;
  logic        mclk;
  logic        sdat;
  logic        lpwr;
  logic [63:0] word;
  int          frames;
  int          mrises;
  int          err_count;
  int          samples_checked;

  pdm_dec_top i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(ce), .BCLK_IN(bclk), .FRAME_SYNC_IN(frame_sync_in),
    .MIC_BITSTREAM_IN(mdat), .MIC_CLOCK_OUT(mclk), .SERIAL_AUDIO_OUT(sdat), .LOW_POWER_OUT(lpwr));
  pdm_host_model i_host (.run(run), .sd(sdat), .mclk(mclk), .bpf(bpf), .bclk(bclk), .fs(frame_sync_in), .mdat(mdat),
    .word(word), .frames(frames), .mrises(mrises));

  always #20 clk_sys = ~clk_sys;

  task automatic chk_v(string name, logic [23:0] exp, logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_n(string name, int exp, int got);
    samples_checked++;
    if (got != exp) begin
      err_count++;
      $display("wrong value %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_reset();
    chk_v("mic clock", 24'h00_0000, {23'h0, mclk});
    chk_v("serial data", 24'h00_0000, {23'h0, sdat});
    chk_v("low power", 24'h00_0001, {23'h0, lpwr});
  endtask

  // Enable low holds shutdown although the host clocks run
  task automatic t_freeze();
    int i;
    ce = 0;
    run = 1;
    for (i = 0; i < 8; i++) begin
      repeat (40) @(negedge clk_sys);
      chk_v("frozen low power", 24'h00_0001, {23'h0, lpwr});
      chk_v("frozen mic clock", 24'h00_0000, {23'h0, mclk});
      chk_v("frozen serial data", 24'h00_0000, {23'h0, sdat});
    end
    ce = 1;
    repeat (20) @(negedge clk_sys);
    chk_v("low power", 24'h00_0000, {23'h0, lpwr});
  endtask

  // Twice the bits per frame: mic clock stops, relocks, 64 periods again
  task automatic t_ratio();
    bpf = 128;
    repeat (2) @(frames);
    @(negedge clk_sys);
    chk_n("mic rises in relock", 0, mrises);
    repeat (5) @(frames);
    @(negedge clk_sys);
    chk_v("low power", 24'h00_0000, {23'h0, lpwr});
    chk_n("mic rises", 64, mrises);
  endtask

  // Ch0 at 75 percent ones, ch1 at 25 percent ones
  task automatic t_start();
    int f;
    run = 1;
    for (f = 1; f <= 66; f++) begin
      @(frames);
      @(negedge clk_sys);
      if (f == 2)
        chk_v("low power", 24'h00_0000, {23'h0, lpwr});
      if (f <= 16)
        chk_n("mic rises", 0, mrises);
      if (f == 30)
        chk_n("mic rises", 64, mrises);
      if (f <= 62)
        chk_v("early word", 24'h00_0000, {23'h0, |word});
    end
    chk_v("ch0 word", 24'h40_0000, word[63:40]);
    chk_v("ch1 word", 24'hC0_0000, word[31:8]);
    chk_v("pad bits", 24'h00_0000, {8'h0, word[39:32], word[7:0]});
  endtask

  task automatic t_stop();
    run = 0;
    repeat (80) @(negedge clk_sys);
    chk_v("low power", 24'h00_0000, {23'h0, lpwr});
    repeat (60) @(negedge clk_sys);
    chk_v("low power", 24'h00_0001, {23'h0, lpwr});
    chk_v("mic clock", 24'h00_0000, {23'h0, mclk});
    chk_v("serial data", 24'h00_0000, {23'h0, sdat});
  endtask

  task automatic t_relock();
    run = 1;
    repeat (22) @(frames);
    @(negedge clk_sys);
    chk_v("low power", 24'h00_0000, {23'h0, lpwr});
    chk_n("mic rises", 64, mrises);
  endtask

  initial begin
    #3_000_000;
    err_count++;
    test_done();
  end

  initial begin
    clk_sys = 0;
    sys_rst = 1;
    ce = 1;
    run = 0;
    bpf = 64;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 0;
    t_reset();
    t_start();
    t_stop();
    t_freeze();
    t_relock();
    t_ratio();
    test_done();
  end
endmodule
